// ---- src/shri_pkg.sv ----
package shri_pkg;
  localparam logic [6:0] TARGET_ADDR      = 7'h40;
  localparam logic [7:0] OFS_STATE        = 8'h00;
  localparam logic [7:0] OFS_RES_HIGH     = 8'h01;
  localparam logic [7:0] OFS_RES_LOW      = 8'h02;
  localparam logic [7:0] OFS_CONTROL      = 8'h03;
  localparam logic [7:0] OFS_IDENTITY     = 8'h11;
  localparam logic [7:0] CMD_FW_FIRST     = 8'h84;
  localparam logic [7:0] CMD_FW_SECOND    = 8'hB8;
  localparam logic [7:0] RST_STATE        = 8'h01;
  localparam logic [7:0] RST_RESULT       = 8'h00;
  localparam logic [7:0] RST_CONTROL      = 8'h00;
  localparam int         BIT_PENDING      = 0;
  localparam int         BIT_START        = 0;
  localparam int         BIT_HEATER       = 1;
  localparam int         BIT_TEMP_SEL     = 4;
  localparam int         BIT_FAST         = 5;
  localparam logic [7:0] CONTROL_RW_MASK  = 8'h33;
  localparam int         CLK_MHZ          = 100;
  localparam int         T_CONV_NORMAL_US = 5800;
  localparam int         T_CONV_FAST_US   = 2600;
  localparam int         CONV_NORMAL_CYC  = T_CONV_NORMAL_US * CLK_MHZ;
  localparam int         CONV_FAST_CYC    = T_CONV_FAST_US * CLK_MHZ;
  localparam int         CONV_CNT_W       = 20;
endpackage : shri_pkg

// ---- src/shri_sync.sv ----
`timescale 1ns/10ps
module shri_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  input  wire logic rst_val,
  output logic      dout
);
  logic stage_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_ff <= 1'b1;
      dout     <= 1'b1;
    end else if (ce) begin
      stage_ff <= din;
      dout     <= stage_ff;
    end
  end
  logic unused_rv;
  assign unused_rv = rst_val;
endmodule : shri_sync

// ---- src/shri_conv.sv ----
`timescale 1ns/10ps
module shri_conv
  import shri_pkg::*;
#(
  parameter int NORMAL_CYC = CONV_NORMAL_CYC,
  parameter int FAST_CYC   = CONV_FAST_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        fast,
  input  wire logic        temp_sel,
  input  wire logic [13:0] sample,
  output logic             busy,
  output logic [15:0]      result
);
  logic [CONV_CNT_W-1:0] cnt_ff;
  logic                  sel_ff;
  // Pending reads 1 from reset until a started conversion ends
  logic                  run_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      busy   <= RST_STATE[BIT_PENDING];
      sel_ff <= 1'b0;
      run_ff <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_ff <= fast ? CONV_CNT_W'(FAST_CYC - 1) : CONV_CNT_W'(NORMAL_CYC - 1);
        busy   <= 1'b1;
        sel_ff <= temp_sel;
        run_ff <= 1'b1;
      end else if (busy && run_ff) begin
        if (cnt_ff == '0) begin
          busy   <= 1'b0;
          run_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= 16'h0000;
    end else if (ce && busy && run_ff && cnt_ff == '0) begin
      result <= sel_ff ? {sample, 2'b00} : {sample, 2'b01};
    end
  end
endmodule : shri_conv

// ---- src/shri_top.sv ----
`timescale 1ns/10ps
module shri_top
  import shri_pkg::*;
#(
  parameter int         NORMAL_CYC  = CONV_NORMAL_CYC,
  parameter int         FAST_CYC    = CONV_FAST_CYC,
  parameter logic [7:0] IDENTITY    = 8'hA0,
  parameter logic [7:0] FW_VERSION  = 8'h12
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        DEVICE_SELECT_LOW_N,
  input  wire logic [13:0] SAMPLE,
  output logic             HEATER_ON,
  output logic             STANDBY
);
  // IDENTITY and FW_VERSION defaults are arbitrary values.
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_DATA, ST_DATA_ACK,
    ST_TX, ST_TX_ACK, ST_IGNORE
  } shri_state_t;

  logic scl_s, sda_s, sel_n_s;
  logic scl_d_ff, sda_d_ff;

  // SCL/SDA sampled at CLK; oversampled protocol engine
  shri_sync u_sync_scl (.clk(CLK), .rst(RST), .ce(CE), .din(SCL), .rst_val(1'b1), .dout(scl_s));
  shri_sync u_sync_sda (.clk(CLK), .rst(RST), .ce(CE), .din(SDA_IN), .rst_val(1'b1), .dout(sda_s));
  shri_sync u_sync_sel (.clk(CLK), .rst(RST), .ce(CE), .din(DEVICE_SELECT_LOW_N), .rst_val(1'b1),
                        .dout(sel_n_s));

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (CE) begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond, enabled;
  assign scl_rise   = scl_s && !scl_d_ff;
  assign scl_fall   = !scl_s && scl_d_ff;
  assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_cond  = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign enabled    = !sel_n_s;
  assign STANDBY    = sel_n_s;

  shri_state_t state_ff;
  logic [7:0]  shift_ff;
  logic [2:0]  bitcnt_ff;
  logic        rw_ff;
  logic [7:0]  ptr_ff;
  logic        cmd_fw_ff;
  logic        fw_sel_ff;
  logic [7:0]  control_ff;
  logic        wr_stb, start_stb;
  logic [7:0]  wr_data;
  logic        conv_busy;
  logic [15:0] conv_result;
  logic        sda_low_ff;
  logic        byte_seen_ff;
  logic [7:0]  rd_byte;

  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic fw, input logic busy,
                                           input logic [15:0] res, input logic [7:0] ctl);
    logic [7:0] v;
    v = 8'h00;
    if (fw) v = FW_VERSION;
    else begin
      case (ofs)
        OFS_STATE:    v = {7'h00, busy};
        OFS_RES_HIGH: v = res[15:8];
        OFS_RES_LOW:  v = res[7:0];
        OFS_CONTROL:  v = ctl & CONTROL_RW_MASK;
        OFS_IDENTITY: v = IDENTITY;
        default:      v = 8'h00;
      endcase
    end
    return v;
  endfunction : reg_read

  assign rd_byte = reg_read(ptr_ff, fw_sel_ff, conv_busy, conv_result, control_ff);

  logic byte_done;
  assign byte_done = scl_rise && bitcnt_ff == 3'd7;

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_ff  <= ST_IDLE;
      shift_ff  <= 8'h00;
      bitcnt_ff <= 3'd0;
      rw_ff     <= 1'b0;
    end else if (CE) begin
      if (!enabled || stop_cond) begin
        state_ff <= ST_IDLE;
      end else if (start_cond) begin
        state_ff  <= ST_ADDR;
        bitcnt_ff <= 3'd0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_PTR, ST_DATA: begin
            if (scl_rise) begin
              shift_ff  <= {shift_ff[6:0], sda_s};
              bitcnt_ff <= bitcnt_ff + 3'd1;
            end
            if (scl_fall && bitcnt_ff == 3'd0 && byte_seen_ff && state_ff == ST_ADDR) begin
              if (shift_ff[7:1] == TARGET_ADDR) begin
                rw_ff    <= shift_ff[0];
                state_ff <= ST_ADDR_ACK;
              end else begin
                state_ff <= ST_IGNORE;
              end
            end else if (scl_fall && bitcnt_ff == 3'd0 && state_ff == ST_PTR && byte_seen_ff) begin
              state_ff <= ST_PTR_ACK;
            end else if (scl_fall && bitcnt_ff == 3'd0 && state_ff == ST_DATA && byte_seen_ff) begin
              state_ff <= ST_DATA_ACK;
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bitcnt_ff <= 3'd0;
              state_ff  <= rw_ff ? ST_TX : ST_PTR;
              if (rw_ff) shift_ff <= reg_read(ptr_ff, fw_sel_ff, conv_busy, conv_result, control_ff);
            end
          end
          ST_PTR_ACK, ST_DATA_ACK: begin
            if (scl_fall) begin
              bitcnt_ff <= 3'd0;
              state_ff  <= ST_DATA;
            end
          end
          ST_TX: begin
            if (scl_fall && bitcnt_ff != 3'd0) shift_ff <= {shift_ff[6:0], 1'b0};
            if (scl_rise) bitcnt_ff <= bitcnt_ff + 3'd1;
            if (scl_fall && bitcnt_ff == 3'd0 && byte_seen_ff) state_ff <= ST_TX_ACK;
          end
          ST_TX_ACK: begin
            if (scl_rise) rw_ff <= !sda_s; // ACK from controller continues
            if (scl_fall) begin
              if (rw_ff) begin
                state_ff  <= ST_TX;
                bitcnt_ff <= 3'd0;
                shift_ff  <= reg_read(ptr_ff, fw_sel_ff, conv_busy, conv_result, control_ff);
              end else begin
                state_ff <= ST_IGNORE; // NACK ends read
              end
            end
          end
          ST_IGNORE, ST_IDLE: begin
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // Marks that eight bits of the current byte were clocked
  always_ff @(posedge CLK) begin
    if (RST) begin
      byte_seen_ff <= 1'b0;
    end else if (CE) begin
      if (start_cond || scl_fall && (state_ff == ST_ADDR_ACK || state_ff == ST_PTR_ACK ||
          state_ff == ST_DATA_ACK || state_ff == ST_TX_ACK)) byte_seen_ff <= 1'b0;
      else if (byte_done) byte_seen_ff <= 1'b1;
    end
  end

  // Pointer and firmware command tracking
  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr_ff    <= OFS_STATE;
      cmd_fw_ff <= 1'b0;
      fw_sel_ff <= 1'b0;
    end else if (CE && enabled) begin
      if (state_ff == ST_PTR_ACK && scl_rise) begin
        ptr_ff    <= shift_ff;
        cmd_fw_ff <= shift_ff == CMD_FW_FIRST;
        fw_sel_ff <= 1'b0;
      end else if (state_ff == ST_DATA_ACK && scl_rise && cmd_fw_ff && shift_ff == CMD_FW_SECOND) begin
        fw_sel_ff <= 1'b1;
        cmd_fw_ff <= 1'b0;
      end else if (state_ff == ST_TX_ACK && scl_rise && !sda_s && !fw_sel_ff &&
                   ptr_ff == OFS_RES_HIGH) begin
        ptr_ff <= OFS_RES_LOW;
      end
    end
  end

  assign wr_stb  = CE && enabled && state_ff == ST_DATA_ACK && scl_rise && !cmd_fw_ff;
  assign wr_data = shift_ff;

  // Only the control register takes writes; others keep contents
  always_ff @(posedge CLK) begin
    if (RST) begin
      control_ff <= RST_CONTROL;
    end else if (wr_stb && ptr_ff == OFS_CONTROL) begin
      control_ff <= wr_data & CONTROL_RW_MASK;
    end
  end
  assign start_stb = wr_stb && ptr_ff == OFS_CONTROL && wr_data[BIT_START];
  assign HEATER_ON = control_ff[BIT_HEATER] && enabled;

  shri_conv #(.NORMAL_CYC(NORMAL_CYC), .FAST_CYC(FAST_CYC)) u_conv (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .start    (start_stb),
    .fast     (wr_data[BIT_FAST]),
    .temp_sel (wr_data[BIT_TEMP_SEL]),
    .sample   (SAMPLE),
    .busy     (conv_busy),
    .result   (conv_result)
  );

  // Open-drain data: drive low for ACK or zero data bits
  always_ff @(posedge CLK) begin
    if (RST) begin
      sda_low_ff <= 1'b0;
    end else if (CE) begin
      if (!enabled) sda_low_ff <= 1'b0;
      else if (scl_fall) begin
        case (state_ff)
          ST_ADDR:                    sda_low_ff <= 1'b0;
          ST_ADDR_ACK:                sda_low_ff <= rw_ff && !rd_byte[7];
          ST_TX:                      sda_low_ff <= bitcnt_ff != 3'd0 && !shift_ff[6];
          ST_TX_ACK:                  sda_low_ff <= rw_ff && !rd_byte[7];
          default:                    sda_low_ff <= 1'b0;
        endcase
        if ((state_ff == ST_ADDR && byte_seen_ff && shift_ff[7:1] == TARGET_ADDR) ||
            (state_ff == ST_PTR && byte_seen_ff) || (state_ff == ST_DATA && byte_seen_ff))
          sda_low_ff <= 1'b1;
      end
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_low_ff;

  sequence ptr_byte_s;
    CE && enabled && !stop_cond && !start_cond && scl_fall && state_ff == ST_PTR && byte_seen_ff;
  endsequence
  sequence ptr_acked_s;
    SDA_OE && state_ff == ST_PTR_ACK;
  endsequence
  ptr_ack_a:       assert property (@(posedge CLK) disable iff (RST)
    ptr_byte_s |=> ptr_acked_s) else $error("pointer byte not acknowledged");
  pending_start_a: assert property (@(posedge CLK) disable iff (RST)
    start_stb |=> conv_busy) else $error("start did not set pending");
  heater_follow_a: assert property (@(posedge CLK) disable iff (RST)
    wr_stb && ptr_ff == OFS_CONTROL |=> control_ff[BIT_HEATER] == $past(wr_data[BIT_HEATER]))
    else $error("heater bit not stored");
  standby_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    sel_n_s [*2] |-> !SDA_OE) else $error("bus driven in standby");
  ro_keep_a:       assert property (@(posedge CLK) disable iff (RST)
    wr_stb && ptr_ff != OFS_CONTROL |=> $stable(control_ff)) else $error("read-only write changed control");
  status_bit_a:    assert property (@(posedge CLK) disable iff (RST)
    reg_read(OFS_STATE, 1'b0, conv_busy, conv_result, control_ff) == {7'h00, conv_busy})
    else $error("status byte wrong");
  fast_time_a:     assert property (@(posedge CLK) disable iff (RST)
    start_stb && wr_data[BIT_FAST] |=> conv_busy [*8]) else $error("fast conversion ended early");
  ptr_adv_a:       assert property (@(posedge CLK) disable iff (RST)
    CE && enabled && state_ff == ST_TX_ACK && scl_rise && !sda_s && !fw_sel_ff && ptr_ff == OFS_RES_HIGH
    |=> ptr_ff == OFS_RES_LOW) else $error("pointer did not advance");
  id_value_a:      assert property (@(posedge CLK) disable iff (RST)
    reg_read(OFS_IDENTITY, 1'b0, conv_busy, conv_result, control_ff) == IDENTITY)
    else $error("identity byte wrong");
endmodule : shri_top

// ---- tb/shri_host.sv ----
`timescale 1ns/10ps
module shri_host (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Bus idles with SCL high and SDA released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half;
    repeat (2) @(posedge lclk);
  endtask : half
  // SDA falls while SCL high; also serves as repeated start
  task automatic start;
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // One clock: drive in low phase, sample at high phase
  task automatic bit_io(input logic b, output logic got);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    got = sda;
    scl = 0;
  endtask : bit_io
  // Writes ncmd command bytes, then reads nrd bytes, acking all but last
  task automatic xfer(input logic [6:0] adr, input logic [15:0] cmd, input int ncmd, input int nrd,
                      output logic [15:0] q, output logic nak);
    logic       a;
    logic [7:0] b;
    logic [8:0] sh;
    nak = 1'b0;
    q   = 16'h0000;
    start();
    for (int k = 0; k <= ncmd; k++) begin
      sh = (k == 0) ? {adr, 1'b0, 1'b1} : {cmd[15-8*(k-1) -: 8], 1'b1};
      for (int i = 8; i >= 0; i--) begin
        bit_io(sh[i], a);
      end
      nak = nak | a;
    end
    if (nrd > 0) begin
      start();
      sh = {adr, 1'b1, 1'b1};
      for (int i = 8; i >= 0; i--) begin
        bit_io(sh[i], a);
      end
      nak = nak | a;
      for (int k = 0; k < nrd; k++) begin
        for (int i = 7; i >= 0; i--) begin
          bit_io(1'b1, b[i]);
        end
        bit_io(k == nrd - 1, a);
        q = {q[7:0], b};
      end
    end
    stop();
  endtask : xfer
endmodule : shri_host

// ---- tb/sensor_i2c_register_interface_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end
module sensor_i2c_register_interface_tb_top;
  import shri_pkg::*;
  localparam logic [7:0] IDV = 8'h5A;  // Arbitrary identity value
  localparam logic [7:0] FWV = 8'h37;  // Arbitrary revision value
  int          bad_count   = 0;
  int          comparisons = 0;
  logic        clk, rst, ce, sel_n, scl, sda_oe, sda_out, heater, standby, host_low, lclk;
  logic [13:0] sample;
  logic [15:0] q, expv;
  logic [31:0] seed, rv;
  logic [7:0]  ctl;
  logic        nk;
  wire  logic  sda = !((sda_oe && !sda_out) || host_low);
  always #5 clk = ~clk;
  initial begin
    lclk = 1'b0;
    #3;
    forever #15 lclk = ~lclk;
  end
  shri_top #(.NORMAL_CYC(4000), .FAST_CYC(2000), .IDENTITY(IDV), .FW_VERSION(FWV)) u_dut (
    .CLK(clk), .RST(rst), .CE(ce), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .DEVICE_SELECT_LOW_N(sel_n), .SAMPLE(sample), .HEATER_ON(heater), .STANDBY(standby));
  shri_host u_host (.lclk(lclk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic summarize;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] d);
    logic k;
    u_host.xfer(TARGET_ADDR, {ptr, 8'h00}, 1, n, d, k);
    `CHK("read ack", 1'b0, k);
  endtask : rd
  // Any offset, data byte sent as given, ack checked
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic        k;
    logic [15:0] x;
    u_host.xfer(TARGET_ADDR, {ptr, d}, 2, 0, x, k);
    `CHK("write ack", 1'b0, k);
  endtask : wr
  function automatic logic [15:0] exp_res(input logic [13:0] s, input logic temp);
    return temp ? {s, 2'b00} : {s, 2'b01};
  endfunction : exp_res
  initial begin
    clk    = 1'b0;
    seed   = 32'h19673594;
    rst    = 1'b1;
    ce     = 1'b1;
    sel_n  = 1'b0;
    sample = 14'h0000;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    rd(OFS_STATE, 1, q);
    `CHK("pending at reset", RST_STATE[BIT_PENDING], q[BIT_PENDING]);
    rd(OFS_IDENTITY, 1, q);
    `CHK("identity", IDV, q[7:0]);
    rd(OFS_CONTROL, 1, q);
    `CHK("control reset", RST_CONTROL, q[7:0] & CONTROL_RW_MASK);
    rd(OFS_RES_HIGH, 2, q);
    `CHK("result reset", {RST_RESULT, RST_RESULT}, q);
    u_host.xfer(TARGET_ADDR, {CMD_FW_FIRST, CMD_FW_SECOND}, 2, 1, q, nk);
    `CHK("revision", FWV, q[7:0]);
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      @(negedge clk);
      sample = rv[29:16];
      ctl    = {2'b00, i[0] ^ rv[3], i[1], 2'b00, rv[0], 1'b1};
      wr(OFS_CONTROL, ctl);
      repeat (2) @(negedge clk);
      `CHK("heater", ctl[BIT_HEATER], heater);
      rd(OFS_STATE, 1, q);
      `CHK("pending after start", 1'b1, q[BIT_PENDING]);
      repeat (2200) @(negedge clk);
      rd(OFS_STATE, 1, q);
      `CHK("pending by speed", ~ctl[BIT_FAST], q[BIT_PENDING]);
      repeat (1500) @(negedge clk);
      rd(OFS_CONTROL, 1, q);
      `CHK("control", ctl & 8'h32, q[7:0] & 8'h32);
      rd(OFS_STATE, 1, q);
      `CHK("pending done", 1'b0, q[BIT_PENDING]);
      expv = exp_res(sample, ctl[BIT_TEMP_SEL]);
      rd(OFS_RES_HIGH, 2, q);
      `CHK("result pair", expv, q);
      wr(OFS_RES_HIGH, ~expv[15:8]);
      rd(OFS_RES_HIGH, 1, q);
      `CHK("result high kept", expv[15:8], q[7:0]);
      rd(OFS_RES_LOW, 1, q);
      `CHK("result low", expv[7:0], q[7:0]);
    end
    u_host.xfer(7'h41, {OFS_STATE, 8'h00}, 1, 0, q, nk);
    `CHK("foreign address nak", 1'b1, nk);
    wr(OFS_CONTROL, 8'h02);
    @(negedge clk);
    sel_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("standby", 1'b1, standby);
    `CHK("heater in standby", 1'b0, heater);
    u_host.xfer(TARGET_ADDR, {OFS_STATE, 8'h00}, 1, 0, q, nk);
    `CHK("deselected nak", 1'b1, nk);
    @(negedge clk);
    sel_n = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("awake", 1'b0, standby);
    summarize();
  end
endmodule : sensor_i2c_register_interface_tb_top
